// >>> srd_pkg.sv
package srd_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int PRESCALE_W  = 8;
   localparam int SCR_W       = 8;
   localparam int FRAME_W     = 16;
   localparam int IRQ_N       = 6;
   localparam int DMA_W       = 3;
   localparam int COUNT_W     = 5;
   localparam int GAP_W       = 16;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_DATA       = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PRESCALE   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_RAW    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASKED = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_DMA_CTRL   = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_RX_FRAMES  = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_DUMMY      = 8'h2C;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_RX_OVERRUN  = 0;
   localparam int BIT_RX_TIMEOUT  = 1;
   localparam int BIT_RX_LEVEL    = 2;
   localparam int BIT_TX_LEVEL    = 3;
   localparam int BIT_TX_UNDERRUN = 4;
   localparam int BIT_TX_EMPTY    = 5;
   localparam int CLR_RX_OVERRUN  = 0;
   localparam int CLR_RX_TIMEOUT  = 1;
   localparam int CLR_TX_UNDERRUN = 2;
   localparam int DMA_RX_BIT      = 0;
   localparam int DMA_TX_BIT      = 2;

   // ************************************************************
   // Reset values and limits
   // ************************************************************
   localparam logic [PRESCALE_W-1:0] RST_PRESCALE  = 8'h00;
   localparam logic [PRESCALE_W-1:0] PRESCALE_MIN  = 8'h02;
   localparam logic [IRQ_N-1:0]      RST_IRQ_MASK  = 6'h00;
   localparam logic [IRQ_N-1:0]      RST_IRQ_RAW   = 6'h00;
   localparam logic [DMA_W-1:0]      RST_DMA_CTRL  = 3'h0;
   localparam logic [FRAME_W-1:0]    RST_RX_FRAMES = 16'h0000;
   localparam logic [DATA_W-1:0]     RST_DUMMY     = 32'h00000000;
   localparam logic [COUNT_W-1:0]    FIFO_DEPTH    = 5'h10;

   // ************************************************************
   // FIFO level trigger codes and their element counts
   // ************************************************************
   typedef enum logic [2:0] {
      SRD_LVL_1 = 3'b000,
      SRD_LVL_4 = 3'b001,
      SRD_LVL_8 = 3'b010
   } srd_level_sel_t;
   localparam logic [COUNT_W-1:0] LVL_CNT_1 = 5'h01;
   localparam logic [COUNT_W-1:0] LVL_CNT_4 = 5'h04;
   localparam logic [COUNT_W-1:0] LVL_CNT_8 = 5'h08;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } srd_bus_req_t;

   typedef struct packed {
      logic [COUNT_W-1:0] rx_count;
      logic [COUNT_W-1:0] tx_count;
      logic               rx_full_write;
      logic               rx_timeout;
      logic               tx_underrun;
   } srd_fifo_stat_t;

endpackage : srd_pkg

// >>> srd_regs.sv
`timescale 1ns/1ns
// How it works
// - bit tick every prescale times one plus factor; no tick while prescale is below 2
// - mask bit0 gates receive overrun interrupt
// - mask bit1 gates receive timeout interrupt
// - mask bit2 gates receive level interrupt
// - mask bit3 gates transmit level interrupt
// - mask bit4 gates transmit underrun interrupt
// - mask bit5 gates transmit empty interrupt
// - raw status shows six conditions unmasked
// - masked status is raw AND mask
// - clear bit0 clears receive overrun
// - clear bit1 clears receive timeout
// - clear bit2 clears transmit underrun
// - DMA bit0 enables receive single requests
// - DMA bit2 enables transmit single requests
// - sixteen-bit receive frame count register
// - receive level hits at 1, 4, 8
// - transmit level hits at 1, 4, 8
// - data read pops unless receive FIFO is empty, data write pushes unless transmit FIFO is full
module srd_regs (
   input  wire logic                            clock,         // Peripheral clock, 25 MHz
   input  wire logic                            arst_n,        // Async reset, active low
   input  wire srd_pkg::srd_bus_req_t           bus,           // Register access request
   output logic [srd_pkg::DATA_W-1:0]           rdata,         // Read data, cycle after read
   input  wire srd_pkg::srd_fifo_stat_t         fifo,          // FIFO levels and events
   input  wire logic [srd_pkg::DATA_W-1:0]      rx_head,       // Word at receive FIFO head
   input  wire logic [srd_pkg::SCR_W-1:0]       serial_clock_rate_factor, // Rate factor
   input  wire logic [2:0]                      rx_irq_level_select, // Receive trigger code
   input  wire logic [2:0]                      tx_irq_level_select, // Transmit trigger code
   output logic                                 rx_pop,        // Pop receive FIFO pulse
   output logic                                 tx_push,       // Push transmit FIFO pulse
   output logic [srd_pkg::DATA_W-1:0]           tx_push_data,  // Word pushed
   output logic                                 bit_tick,      // One pulse per bit period
   output logic                                 rx_dma_req,    // Receive single DMA request
   output logic                                 tx_dma_req,    // Transmit single DMA request
   output logic [srd_pkg::FRAME_W-1:0]          rx_frame_count,// Frames to receive
   output logic [srd_pkg::DATA_W-1:0]           dummy_char,    // Filler word for shifting out
   output logic                                 use_dummy,     // Shift dummy word instead
   output logic                                 irq            // Combined interrupt
);
   import srd_pkg::*;

   // ************************************************************
   // Decoding shared by both trigger paths
   // ************************************************************
   function automatic logic level_hit(input logic [2:0] sel, input logic [COUNT_W-1:0] cnt);
      case (sel)
         SRD_LVL_1: level_hit = (cnt >= LVL_CNT_1);
         SRD_LVL_4: level_hit = (cnt >= LVL_CNT_4);
         SRD_LVL_8: level_hit = (cnt >= LVL_CNT_8);
         default:   level_hit = 1'b0; // Reserved codes never trigger
      endcase
   endfunction : level_hit

   // ************************************************************
   // Registers and strobes
   // ************************************************************
   logic [PRESCALE_W-1:0] prescale_divisor;
   logic [IRQ_N-1:0]      irq_mask;
   logic [IRQ_N-1:0]      irq_raw_status;
   logic [DMA_W-1:0]      dma_control;
   logic [PRESCALE_W-1:0] pre_cnt;
   logic [SCR_W-1:0]      scr_cnt;
   logic [IRQ_N-1:0]      irq_masked_status;
   logic                  wr_mask;
   logic                  wr_clear;
   logic                  rd_data;

   assign wr_mask  = bus.wr && (bus.addr == OFS_IRQ_MASK);
   assign wr_clear = bus.wr && (bus.addr == OFS_IRQ_CLEAR);
   assign rd_data  = bus.rd && (bus.addr == OFS_DATA);
   assign irq_masked_status = irq_raw_status & irq_mask;

   // Writable configuration; status offsets ignore writes
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prescale_divisor <= RST_PRESCALE;
         irq_mask         <= RST_IRQ_MASK;
         dma_control      <= RST_DMA_CTRL;
         rx_frame_count   <= RST_RX_FRAMES;
         dummy_char       <= RST_DUMMY;
      end else if (bus.wr) begin
         case (bus.addr)
            OFS_PRESCALE:  prescale_divisor <= bus.wdata[PRESCALE_W-1:0];
            OFS_IRQ_MASK:  irq_mask         <= bus.wdata[IRQ_N-1:0];
            OFS_DMA_CTRL:  begin // Reserved middle bit stays at its reset zero
               dma_control[DMA_RX_BIT] <= bus.wdata[DMA_RX_BIT];
               dma_control[DMA_TX_BIT] <= bus.wdata[DMA_TX_BIT];
            end
            OFS_RX_FRAMES: rx_frame_count   <= bus.wdata[FRAME_W-1:0];
            OFS_DUMMY:     dummy_char       <= bus.wdata;
            default:       ;
         endcase
      end
   end

   // Read mux; reserved bits and write-only offsets read zero
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (bus.rd) begin
         case (bus.addr)
            OFS_DATA:       rdata <= rx_head;
            OFS_PRESCALE:   rdata <= {24'h000000, prescale_divisor};
            OFS_IRQ_MASK:   rdata <= {26'h0000000, irq_mask};
            OFS_IRQ_RAW:    rdata <= {26'h0000000, irq_raw_status};
            OFS_IRQ_MASKED: rdata <= {26'h0000000, irq_masked_status};
            OFS_DMA_CTRL:   rdata <= {29'h00000000, dma_control};
            OFS_RX_FRAMES:  rdata <= {16'h0000, rx_frame_count};
            OFS_DUMMY:      rdata <= dummy_char;
            default:        rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ************************************************************
   // FIFO data port
   // ************************************************************
   // Popping an empty FIFO would corrupt its pointers, so it is skipped
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_pop       <= 1'b0;
         tx_push      <= 1'b0;
         tx_push_data <= '0;
      end else begin
         rx_pop  <= rd_data && (fifo.rx_count != '0);
         tx_push <= bus.wr && (bus.addr == OFS_DATA) && (fifo.tx_count != FIFO_DEPTH);
         if (bus.wr && (bus.addr == OFS_DATA)) begin
            tx_push_data <= bus.wdata;
         end
      end
   end

   // ************************************************************
   // Interrupt status
   // ************************************************************
   // Sticky events: a new event in the clearing cycle wins over the clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq_raw_status <= RST_IRQ_RAW;
      end else begin
         irq_raw_status[BIT_RX_OVERRUN] <= fifo.rx_full_write
            || (irq_raw_status[BIT_RX_OVERRUN]
            && !(wr_clear && bus.wdata[CLR_RX_OVERRUN]));
         irq_raw_status[BIT_RX_TIMEOUT] <= fifo.rx_timeout
            || (irq_raw_status[BIT_RX_TIMEOUT]
            && !(wr_clear && bus.wdata[CLR_RX_TIMEOUT]));
         irq_raw_status[BIT_TX_UNDERRUN] <= fifo.tx_underrun
            || (irq_raw_status[BIT_TX_UNDERRUN]
            && !(wr_clear && bus.wdata[CLR_TX_UNDERRUN]));
         // Level conditions follow the FIFO and have no clear bit
         irq_raw_status[BIT_RX_LEVEL] <= level_hit(rx_irq_level_select, fifo.rx_count);
         irq_raw_status[BIT_TX_LEVEL] <= level_hit(tx_irq_level_select, fifo.tx_count);
         irq_raw_status[BIT_TX_EMPTY] <= (fifo.tx_count == '0);
      end
   end

   // Single output line, one cycle behind the masked status
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |irq_masked_status;
      end
   end

   // ************************************************************
   // DMA requests and dummy fill
   // ************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_dma_req <= 1'b0;
         tx_dma_req <= 1'b0;
         use_dummy  <= 1'b0;
      end else begin
         rx_dma_req <= dma_control[DMA_RX_BIT] && (fifo.rx_count != '0);
         tx_dma_req <= dma_control[DMA_TX_BIT] && (fifo.tx_count != FIFO_DEPTH);
         use_dummy  <= (rx_frame_count != '0) && (fifo.tx_count == '0);
      end
   end

   // ************************************************************
   // Bit-rate generator
   // ************************************************************
   // A divisor below the minimum stops the rate rather than run too fast
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pre_cnt  <= '0;
         scr_cnt  <= '0;
         bit_tick <= 1'b0;
      end else if (prescale_divisor < PRESCALE_MIN) begin
         pre_cnt  <= '0;
         scr_cnt  <= '0;
         bit_tick <= 1'b0;
      end else if (pre_cnt >= prescale_divisor - 8'h01) begin
         pre_cnt <= '0;
         if (scr_cnt >= serial_clock_rate_factor) begin
            scr_cnt  <= '0;
            bit_tick <= 1'b1;
         end else begin
            scr_cnt  <= scr_cnt + 8'h01;
            bit_tick <= 1'b0;
         end
      end else begin
         pre_cnt  <= pre_cnt + 8'h01;
         bit_tick <= 1'b0;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // Period tracking; restarts whenever the divisor settings move
   logic [GAP_W-1:0] gap;
   logic             clean;
   logic [GAP_W-1:0] exp_gap;
   assign exp_gap = {8'h00, prescale_divisor} * ({8'h00, serial_clock_rate_factor} + 16'h0001);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gap   <= '0;
         clean <= 1'b0;
      end else begin
         gap <= bit_tick ? 16'h0001 : gap + 16'h0001;
         if ((bus.wr && (bus.addr == OFS_PRESCALE)) || $changed(serial_clock_rate_factor)
             || (prescale_divisor < PRESCALE_MIN)) begin
            clean <= 1'b0;
         end else if (bit_tick) begin
            clean <= 1'b1;
         end
      end
   end

   sequence s_raw_then_irq(int b);
      irq_raw_status[b] ##1 irq;
   endsequence

   property p_rate;
      bit_tick && clean && !$changed(serial_clock_rate_factor) |-> gap == exp_gap;
   endproperty
   a_rate: assert property (p_rate) else $error("bit period wrong");

   property p_overrun_irq;
      fifo.rx_full_write && irq_mask[BIT_RX_OVERRUN] && !wr_mask |=> s_raw_then_irq(BIT_RX_OVERRUN);
   endproperty
   a_overrun_irq: assert property (p_overrun_irq) else $error("overrun irq missing");

   property p_timeout_irq;
      fifo.rx_timeout && irq_mask[BIT_RX_TIMEOUT] && !wr_mask |=> s_raw_then_irq(BIT_RX_TIMEOUT);
   endproperty
   a_timeout_irq: assert property (p_timeout_irq) else $error("timeout irq missing");

   property p_masked_quiet;
      (irq_mask == '0) && !wr_mask |=> (irq_mask == '0) ##1 !irq;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("irq while all masked");

   property p_clear_overrun;
      wr_clear && bus.wdata[CLR_RX_OVERRUN] && !fifo.rx_full_write |=> !irq_raw_status[BIT_RX_OVERRUN];
   endproperty
   a_clear_overrun: assert property (p_clear_overrun) else $error("overrun not cleared");

   property p_clear_timeout;
      wr_clear && bus.wdata[CLR_RX_TIMEOUT] && !fifo.rx_timeout |=> !irq_raw_status[BIT_RX_TIMEOUT];
   endproperty
   a_clear_timeout: assert property (p_clear_timeout) else $error("timeout not cleared");

   property p_clear_underrun;
      wr_clear && bus.wdata[CLR_TX_UNDERRUN] && !fifo.tx_underrun
         |=> !irq_raw_status[BIT_TX_UNDERRUN];
   endproperty
   a_clear_underrun: assert property (p_clear_underrun) else $error("underrun not cleared");

   property p_set_wins;
      wr_clear && bus.wdata[CLR_RX_OVERRUN] && fifo.rx_full_write |=> irq_raw_status[BIT_RX_OVERRUN];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   property p_rx_dma_off;
      !dma_control[DMA_RX_BIT] |=> !rx_dma_req;
   endproperty
   a_rx_dma_off: assert property (p_rx_dma_off) else $error("rx dma while disabled");

   property p_tx_dma_off;
      !dma_control[DMA_TX_BIT] |=> !tx_dma_req;
   endproperty
   a_tx_dma_off: assert property (p_tx_dma_off) else $error("tx dma while disabled");

   property p_rx_level4;
      (rx_irq_level_select == SRD_LVL_4) && (fifo.rx_count >= LVL_CNT_4)
         |=> irq_raw_status[BIT_RX_LEVEL];
   endproperty
   a_rx_level4: assert property (p_rx_level4) else $error("rx level miss");

   property p_tx_level8;
      (tx_irq_level_select == SRD_LVL_8) && (fifo.tx_count < LVL_CNT_8)
         |=> !irq_raw_status[BIT_TX_LEVEL];
   endproperty
   a_tx_level8: assert property (p_tx_level8) else $error("tx level false hit");

   property p_pop_once;
      rd_data && (fifo.rx_count != '0) ##1 !bus.rd |=> !rx_pop;
   endproperty
   a_pop_once: assert property (p_pop_once) else $error("pop held too long");

   property p_pop;
      rd_data && (fifo.rx_count != '0) |=> rx_pop;
   endproperty
   a_pop: assert property (p_pop) else $error("no pop on data read");

   property p_underrun_irq;
      fifo.tx_underrun && irq_mask[BIT_TX_UNDERRUN] && !wr_mask
         |=> s_raw_then_irq(BIT_TX_UNDERRUN);
   endproperty
   a_underrun_irq: assert property (p_underrun_irq) else $error("underrun irq missing");

   property p_rx_level_irq;
      irq_raw_status[BIT_RX_LEVEL] && irq_mask[BIT_RX_LEVEL] |=> irq;
   endproperty
   a_rx_level_irq: assert property (p_rx_level_irq) else $error("rx level irq missing");

   property p_tx_level_irq;
      irq_raw_status[BIT_TX_LEVEL] && irq_mask[BIT_TX_LEVEL] |=> irq;
   endproperty
   a_tx_level_irq: assert property (p_tx_level_irq) else $error("tx level irq missing");

   property p_empty_irq;
      irq_raw_status[BIT_TX_EMPTY] && irq_mask[BIT_TX_EMPTY] |=> irq;
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("empty irq missing");

   property p_empty_raw;
      (fifo.tx_count == '0) |=> irq_raw_status[BIT_TX_EMPTY];
   endproperty
   a_empty_raw: assert property (p_empty_raw) else $error("empty status missing");

   property p_rx_dma_on;
      dma_control[DMA_RX_BIT] && (fifo.rx_count != '0) |=> rx_dma_req;
   endproperty
   a_rx_dma_on: assert property (p_rx_dma_on) else $error("rx dma missing");

   property p_tx_dma_on;
      dma_control[DMA_TX_BIT] && (fifo.tx_count != FIFO_DEPTH) |=> tx_dma_req;
   endproperty
   a_tx_dma_on: assert property (p_tx_dma_on) else $error("tx dma missing");

   property p_push;
      bus.wr && (bus.addr == OFS_DATA) && (fifo.tx_count != FIFO_DEPTH)
         |=> tx_push && (tx_push_data == $past(bus.wdata));
   endproperty
   a_push: assert property (p_push) else $error("no push on data write");

   property p_rdata_idle;
      !bus.rd |=> (rdata == '0);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

   property p_masked_read;
      bus.rd && (bus.addr == OFS_IRQ_MASKED)
         |=> rdata == {26'h0000000, $past(irq_masked_status)};
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("masked read wrong");

   property p_raw_read;
      bus.rd && (bus.addr == OFS_IRQ_RAW)
         |=> rdata == {26'h0000000, $past(irq_raw_status)};
   endproperty
   a_raw_read: assert property (p_raw_read) else $error("raw read wrong");

   property p_dummy;
      (rx_frame_count != '0) && (fifo.tx_count == '0) |=> use_dummy;
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy fill missing");

endmodule : srd_regs

// >>> srd_fifo_model.sv
`timescale 1ns/1ns
// Far side: serial engine with its FIFO levels, event pulses and head word
module srd_fifo_model (
   input  wire logic               clock,   // Peripheral clock
   input  wire logic               arst_n,  // Async reset, active low
   input  wire logic [2:0]         ev,      // Rx frame, tx frame out, rx timeout
   input  wire logic [31:0]        rx_word, // Word of the incoming frame
   input  wire logic               rx_pop,  // Pop request from block
   input  wire logic               tx_push, // Push request from block
   output srd_pkg::srd_fifo_stat_t fifo,    // Levels and event pulses
   output logic [31:0]             rx_head  // Word at receive head
);
   import srd_pkg::*;
   logic [31:0]        rq[$];
   logic [31:0]        last;
   int                 tc;
   logic [COUNT_W-1:0] rco;
   logic [COUNT_W-1:0] tco;
   // ****************
   // Events
   // ****************
   // Events are judged against the level that stood when the frame came
   assign fifo = '{rco, tco, ev[0] && rco == FIFO_DEPTH, ev[2], ev[1] && tco == 5'h00};
   // ****************
   // Storage
   // ****************
   // Outputs go out by NBA so the block always samples the old level
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rq.delete();
         last = 32'h0;
         tc = 0;
         rco <= 5'h00;
         tco <= 5'h00;
         rx_head <= 32'hFFFFFFFF;
      end else begin
         if (ev[0] && rq.size() < 16) begin
            rq.push_back(rx_word);
         end
         if (rx_pop && rq.size() > 0) begin
            last = rq.pop_front();
         end
         if (tx_push && tc < 16) begin
            tc++;
         end
         if (ev[1] && tc > 0) begin
            tc--;
         end
         rco <= COUNT_W'(rq.size());
         tco <= COUNT_W'(tc);
         // A drained head shows the inverse of the last word, never a stale copy
         rx_head <= rq.size() != 0 ? rq[0] : ~last;
      end
   end
endmodule : srd_fifo_model

// >>> srd_regs_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench: integer and queue model against the register block
module srd_regs_tb_top;
   import srd_pkg::*;
   logic           clock = 1'b0;
   logic           arst_n = 1'b0;
   srd_bus_req_t   bus = '0;
   logic [2:0]     ev = 3'h0;
   logic [31:0]    rx_word = 32'h0;
   logic [7:0]     factor = 8'h00;
   logic [2:0]     rsel = 3'h0;
   logic [2:0]     tsel = 3'h0;
   srd_fifo_stat_t fifo;
   logic [31:0]    rdata, rx_head, tx_push_data, dummy_char, d, t;
   logic [15:0]    rx_frame_count, frm;
   logic           rx_pop, tx_push, bit_tick, rx_dma_req, tx_dma_req, use_dummy, irq;
   logic           ovr = 1'b0, tov = 1'b0, und = 1'b0;
   logic [5:0]     mask;
   logic [2:0]     dma;
   logic [31:0]    rq[$];
   logic [31:0]    vals[9];
   int             n_mismatch = 0, checked = 0, nrx = 0, ntx = 0, code;
   localparam logic [7:0] ADR[9] = '{OFS_PRESCALE, OFS_IRQ_MASK, OFS_IRQ_RAW, OFS_IRQ_MASKED,
      OFS_IRQ_CLEAR, OFS_DMA_CTRL, OFS_RX_FRAMES, OFS_DUMMY, 8'h40};
   localparam logic [31:0] WM[9] = '{32'hFF, 32'h3F, 0, 0, 0, 32'h5, 32'hFFFF, '1, 0};

   // Free-running peripheral clock
   always #20 clock = ~clock;

   srd_regs dut (.clock, .arst_n, .bus, .rdata, .fifo, .rx_head,
      .serial_clock_rate_factor(factor), .rx_irq_level_select(rsel),
      .tx_irq_level_select(tsel), .rx_pop, .tx_push, .tx_push_data, .bit_tick,
      .rx_dma_req, .tx_dma_req, .rx_frame_count, .dummy_char, .use_dummy, .irq);
   srd_fifo_model far (.clock, .arst_n, .ev, .rx_word, .rx_pop, .tx_push, .fifo, .rx_head);

   // ****************
   // Helpers
   // ****************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clock);
      bus <= '0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock);
      bus <= '0;
      #1 v = rdata;
   endtask : rd
   task pulse(input logic [2:0] e);
      @(posedge clock);
      ev <= e;
      @(posedge clock);
      ev <= 3'h0;
   endtask : pulse
   function int thr(input logic [2:0] c);
      return c == 3'b000 ? 1 : c == 3'b001 ? 4 : c == 3'b010 ? 8 : 99;
   endfunction : thr
   function logic [5:0] raw();
      return {ntx == 0, und, ntx >= thr(tsel), nrx >= thr(rsel), tov, ovr};
   endfunction : raw
   // Waits out the three-cycle status lag before looking
   task status;
      repeat (3) @(posedge clock);
      rd(OFS_IRQ_RAW, d);
      chk("raw", d, {26'h0, raw()});
      rd(OFS_IRQ_MASKED, d);
      chk("masked", d, {26'h0, raw() & mask});
      chk("irq", irq, |(raw() & mask));
      chk("rx_dma", rx_dma_req, dma[0] && nrx != 0);
      chk("tx_dma", tx_dma_req, dma[2] && ntx != 16);
      chk("use_dummy", use_dummy, frm != 0 && ntx == 0);
   endtask : status
   // One frame in each way: data write, then a received frame
   task put;
      logic p;
      t = $urandom;
      p = ntx < 16;
      wr(OFS_DATA, t);
      #1 chk("tx_push", tx_push, p);
      ntx += p;
      rx_word <= ~t;
      if (nrx == 16) ovr = 1'b1;
      else begin
         rq.push_back(~t);
         nrx++;
      end
      pulse(3'b001);
      if (p) chk("push_data", tx_push_data, t);
      status;
   endtask : put
   task take;
      rd(OFS_DATA, d);
      chk("rx_pop", rx_pop, nrx > 0);
      if (nrx > 0) begin
         nrx--;
         chk("rx_data", d, rq.pop_front());
      end
      if (ntx == 0) und = 1'b1;
      else ntx--;
      pulse(3'b010);
      status;
   endtask : take
   task rate(input int p, input int f);
      int n;
      factor <= f[7:0];
      wr(OFS_PRESCALE, p);
      for (int j = 0; j < 3; j++) begin
         n = 1;
         @(posedge clock);
         while (bit_tick !== 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
         end
      end
      chk("bit_period", n, p * (1 + f));
   endtask : rate
   task results;
      if (n_mismatch == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   // ****************
   // Tests
   // ****************
   initial begin
      t = $urandom(32'hCA0B);
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      // Reset values, then random write and read back of every offset except data
      for (code = 0; code < 9; code++) begin
         rd(ADR[code], d);
         chk("reset", d, code == 2 ? 32'h20 : 32'h0);
      end
      for (code = 0; code < 9; code++) begin
         vals[code] = code == 0 ? 32'h2 + 2 * ($urandom % 127) : $urandom;
         wr(ADR[code], vals[code]);
      end
      mask = vals[1][5:0];
      dma = vals[5][2:0];
      frm = vals[6][15:0];
      for (code = 0; code < 9; code++) begin
         rd(ADR[code], d);
         t = code == 2 ? {26'h0, raw()} : code == 3 ? {26'h0, raw() & mask} :
            vals[code] & WM[code];
         chk("reg", d, t);
      end
      chk("frames", rx_frame_count, frm);
      chk("dummy", dummy_char, vals[7]);
      // Fill past full and drain past empty under trigger codes 0 to 3
      for (code = 0; code < 4; code++) begin
         rsel <= code[2:0];
         tsel <= 3'(3 - code);
         mask = code == 0 ? 6'h3F : code == 3 ? 6'h00 : code == 1 ? 6'h03 | $urandom : $urandom;
         wr(OFS_IRQ_MASK, mask);
         dma = $urandom;
         wr(OFS_DMA_CTRL, dma);
         frm = code[0] ? $urandom : 0;
         wr(OFS_RX_FRAMES, frm);
         if (code == 1) begin
            tov = 1'b1;
            pulse(3'b100);
         end
         repeat (17) put;
         // Clear and a fresh overrun in one cycle: the event must survive
         fork
            wr(OFS_IRQ_CLEAR, 32'h1);
            pulse(3'b001);
         join
         ovr = 1'b1;
         status;
         repeat (17) take;
         t = code == 3 ? 32'h7 : $urandom;
         wr(OFS_IRQ_CLEAR, t);
         ovr &= ~t[0];
         tov &= ~t[1];
         und &= ~t[2];
         status;
      end
      rate(4, 2);
      rate(2, 0);
      rate(254, 1);
      results;
   end

   // Cuts a hang short well beyond the expected run
   initial begin
      repeat (60000) @(posedge clock);
      n_mismatch++;
      results;
   end
endmodule : srd_regs_tb_top
